// *** design/usart_defines.svh ***
// Register offsets, field positions, reset values and timing counts of the serial data path
`ifndef USART_DEFINES_SVH
`define USART_DEFINES_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define OFS_DATA_PORT 8'h00
`define OFS_CTRL_STATUS_A 8'h04
`define OFS_CTRL_STATUS_B 8'h08
`define OFS_FRAME_CFG 8'h0c
`define OFS_BAUD_DIV 8'h10

// ----------------------------------------
// ctrl_status_a fields
// ----------------------------------------
`define CSA_RX_READY 7
`define CSA_TX_DONE 6
`define CSA_TX_EMPTY 5
`define CSA_FRAME_ERR 4
`define CSA_OVERRUN 3
`define CSA_PARITY_ERR 2

// ----------------------------------------
// ctrl_status_b fields
// ----------------------------------------
`define CSB_TX_DONE_IE 6
`define CSB_TX_EMPTY_IE 5
`define CSB_RX_ON 4
`define CSB_TX_ON 3
`define CSB_RX_NINTH 1
`define CSB_TX_NINTH 0

// ----------------------------------------
// frame_cfg fields
// ----------------------------------------
`define CFG_SIZE_LSB 0
`define CFG_SIZE_MSB 2
`define CFG_PAR_LSB 4
`define CFG_PAR_MSB 5
`define CFG_TWO_STOP 6
`define CFG_SYNC 7

// ----------------------------------------
// Reset values, timing counts and the nine-bit size code
// ----------------------------------------
`define CFG_RST 8'h03
`define BAUD_DIV_RST 12'h043
`define OS_LAST 4'hf
`define OS_MID 4'h7
`define CHAR_SIZE_NINE 3'h7

`endif

// *** design/usart_pkg.sv ***
// Types shared by the serial data path and its tick generator
package usart_pkg;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_START = 3'b001,
    TX_DATA = 3'b010,
    TX_PAR = 3'b011,
    TX_STOP = 3'b100
  } tx_state_t;

  typedef enum logic [2:0] {
    RX_IDLE = 3'b000,
    RX_START = 3'b001,
    RX_DATA = 3'b010,
    RX_PAR = 3'b011,
    RX_STOP = 3'b100
  } rx_state_t;

  typedef struct packed {
    logic sync_mode;
    logic two_stop;
    logic [1:0] parity_mode;
    logic [2:0] char_size_sel;
  } frame_cfg_t;

  typedef struct packed {
    logic frame_err;
    logic overrun;
    logic parity_err;
    logic ninth;
    logic [7:0] data;
  } rx_entry_t;

  typedef struct packed {
    logic [11:0] cnt;
    logic tick;
    logic xck_q;
    logic rise;
    logic fall;
  } tick_state_t;

  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    frame_cfg_t cfg;
    logic [11:0] baud_div;
    logic tx_empty_ie;
    logic tx_done_ie;
    logic rx_on;
    logic tx_on;
    logic tx_ninth_bit;
    logic tx_done;
    logic tx_en_eff;
    logic [8:0] tx_buf;
    logic tx_buf_valid;
    tx_state_t tx_st;
    logic [8:0] tx_sh;
    logic tx_par;
    logic [3:0] tx_bitn;
    logic [3:0] tx_sub;
    logic txd;
    rx_state_t rx_st;
    logic [8:0] rx_sh;
    logic rx_parbit;
    logic [3:0] rx_bitn;
    logic [3:0] rx_sub;
    rx_entry_t [1:0] fifo;
    logic rd_ptr;
    logic [1:0] count;
    rx_entry_t hold;
    logic hold_valid;
    logic tx_empty_irq;
    logic tx_done_irq;
  } state_t;

endpackage

// *** design/bit_tick_gen.sv ***
// Oversampling tick divider and external transfer clock edge detector
`timescale 1ns/1ps
module bit_tick_gen
  import usart_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Rate control
  input wire logic [11:0] baud_div_i,
  input wire logic xck_i,
  // Enables
  output logic os_tick_o,
  output logic xck_rise_o,
  output logic xck_fall_o
);

  tick_state_t s_r;
  tick_state_t s_nxt;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_nxt = s_r;
    // Divisor of zero still yields a tick every cycle
    if (s_r.cnt >= baud_div_i) begin
      s_nxt.cnt = 12'h000;
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.cnt = s_r.cnt + 12'h001;
      s_nxt.tick = 1'b0;
    end
    s_nxt.xck_q = xck_i;
    s_nxt.rise = xck_i & ~s_r.xck_q;
    s_nxt.fall = ~xck_i & s_r.xck_q;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign os_tick_o = s_r.tick;
  assign xck_rise_o = s_r.rise;
  assign xck_fall_o = s_r.fall;

endmodule

// *** design/usart_datapath.sv ***
// Serial transmit and receive data path with Wishbone register access
//
// Summary of operation
// - Ninth data bit travels with a nine-bit character, marking address frames if used.
// - Transmit-empty flag is high while the transmit buffer holds no unmoved data.
// - Buffer-empty interrupt requested while flag set, enable set, interrupts globally on.
// - Writing a character to the data port clears the transmit-empty flag.
// - Transmit-done flag sets when a frame ends and no character waits.
// - Transmit-done clears on interrupt service or by writing one to it.
// - Transmit-complete interrupt raised when done flag sets, if its enable is set and interrupts globally on.
// - With parity enabled, parity bit goes after data, before first stop bit.
// - Disabling the transmitter waits until shift register and buffer are empty.
// - A disabled transmitter releases the serial output pin to the port.
// - While receiver is on, it takes the serial input pin.
// - Synchronous mode clocks the receiver from the external transfer clock.
// - Reception starts on a valid start bit; bits then sampled and shifted.
// - First stop bit ends the frame; a second stop bit is ignored.
// - On the first stop bit the frame moves into the receive buffer.
// - Unused high data bits read back as zero for short characters.
// - Ninth bit and error flags stored per character; data read advances.
// - Shift register loads when idle or right after the last stop bit.
// - Receive-ready flag high while unread characters remain in the buffer.
// - Receive buffer holds two characters, third waits in a separate hold register.
`timescale 1ns/1ps
`include "usart_defines.svh"
module usart_datapath
  import usart_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Serial pins
  input wire logic serial_in_i,
  input wire logic ext_serial_clk_i,
  output logic serial_out_o,
  output logic tx_override_o,
  output logic rx_override_o,
  // Interrupt requests
  input wire logic global_irq_en_i,
  input wire logic tx_done_serviced_i,
  output logic tx_empty_irq_o,
  output logic tx_done_irq_o
);

  state_t s_r;
  state_t s_nxt;
  logic os_tick;
  logic xck_rise;
  logic xck_fall;

  // ----------------------------------------
  // Character size decoding
  // ----------------------------------------
  function automatic logic [3:0] char_bits(input logic [2:0] sel);
    logic [3:0] b;
    b = 4'h8;
    case (sel)
      3'h0: b = 4'h5;
      3'h1: b = 4'h6;
      3'h2: b = 4'h7;
      `CHAR_SIZE_NINE: b = 4'h9;
      default: b = 4'h8;
    endcase
    return b;
  endfunction

  function automatic logic [8:0] char_mask(input logic [2:0] sel);
    return 9'h1ff >> (4'h9 - char_bits(sel));
  endfunction

  bit_tick_gen u_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .baud_div_i(s_r.baud_div),
    .xck_i(ext_serial_clk_i),
    .os_tick_o(os_tick),
    .xck_rise_o(xck_rise),
    .xck_fall_o(xck_fall)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic acc;
    logic wr;
    logic rd;
    logic [7:0] ofs;
    logic tx_step;
    logic rx_samp;
    logic rxd;
    logic pop;
    logic push;
    logic [3:0] nbits;
    logic [8:0] mask;
    logic [8:0] rdata;
    rx_entry_t head;
    rx_entry_t ent;
    acc = cyc_i & stb_i & ~s_r.ack;
    wr = acc & we_i & sel_i[0];
    rd = acc & ~we_i;
    ofs = {adr_i[7:2], 2'b00};
    pop = 1'b0;
    push = 1'b0;
    ent = '0;
    s_nxt = s_r;
    nbits = char_bits(s_r.cfg.char_size_sel);
    mask = char_mask(s_r.cfg.char_size_sel);
    rdata = (s_r.rx_sh >> (4'h9 - nbits)) & mask;
    head = (s_r.count != 2'h0) ? s_r.fifo[s_r.rd_ptr] : '0;
    // Receiver sees an idle line unless it owns the pin
    rxd = s_r.rx_on ? serial_in_i : 1'b1;
    tx_step = s_r.cfg.sync_mode ? xck_fall : (os_tick && s_r.tx_sub == `OS_LAST);
    rx_samp = s_r.cfg.sync_mode ? xck_rise : (os_tick && s_r.rx_sub == `OS_LAST);

    // ----------------------------------------
    // Register reads
    // ----------------------------------------
    s_nxt.ack = acc;
    s_nxt.rdat = 32'h0000_0000;
    if (rd) begin
      if (ofs == `OFS_DATA_PORT) begin
        s_nxt.rdat[7:0] = head.data;
        pop = (s_r.count != 2'h0);
      end else if (ofs == `OFS_CTRL_STATUS_A) begin
        s_nxt.rdat[`CSA_RX_READY] = (s_r.count != 2'h0);
        s_nxt.rdat[`CSA_TX_DONE] = s_r.tx_done;
        s_nxt.rdat[`CSA_TX_EMPTY] = ~s_r.tx_buf_valid;
        s_nxt.rdat[`CSA_FRAME_ERR] = head.frame_err;
        s_nxt.rdat[`CSA_OVERRUN] = head.overrun;
        s_nxt.rdat[`CSA_PARITY_ERR] = head.parity_err;
      end else if (ofs == `OFS_CTRL_STATUS_B) begin
        s_nxt.rdat[`CSB_TX_DONE_IE] = s_r.tx_done_ie;
        s_nxt.rdat[`CSB_TX_EMPTY_IE] = s_r.tx_empty_ie;
        s_nxt.rdat[`CSB_RX_ON] = s_r.rx_on;
        s_nxt.rdat[`CSB_TX_ON] = s_r.tx_on;
        s_nxt.rdat[`CSB_RX_NINTH] = head.ninth;
        s_nxt.rdat[`CSB_TX_NINTH] = s_r.tx_ninth_bit;
      end else if (ofs == `OFS_FRAME_CFG) begin
        s_nxt.rdat[7:0] = {s_r.cfg.sync_mode, s_r.cfg.two_stop, s_r.cfg.parity_mode,
                           1'b0, s_r.cfg.char_size_sel};
      end else if (ofs == `OFS_BAUD_DIV) begin
        s_nxt.rdat[11:0] = s_r.baud_div;
      end
    end

    // ----------------------------------------
    // Transmitter
    // ----------------------------------------
    if (os_tick) begin
      s_nxt.tx_sub = s_r.tx_sub + 4'h1;
    end
    // Enable only drops once nothing is left to send
    s_nxt.tx_en_eff = s_r.tx_on |
                      (s_r.tx_en_eff & ((s_r.tx_st != TX_IDLE) | s_r.tx_buf_valid));
    if (tx_step) begin
      unique case (s_r.tx_st)
        TX_IDLE: begin
          s_nxt.txd = 1'b1;
          if (s_r.tx_buf_valid && s_r.tx_en_eff) begin
            s_nxt.tx_st = TX_START;
          end
        end
        TX_START: begin
          s_nxt.txd = s_r.tx_sh[0];
          s_nxt.tx_sh = {1'b0, s_r.tx_sh[8:1]};
          s_nxt.tx_bitn = 4'h1;
          s_nxt.tx_st = TX_DATA;
        end
        TX_DATA: begin
          if (s_r.tx_bitn == nbits) begin
            s_nxt.tx_bitn = 4'h0;
            if (s_r.cfg.parity_mode[1]) begin
              s_nxt.txd = s_r.tx_par;
              s_nxt.tx_st = TX_PAR;
            end else begin
              s_nxt.txd = 1'b1;
              s_nxt.tx_st = TX_STOP;
            end
          end else begin
            s_nxt.txd = s_r.tx_sh[0];
            s_nxt.tx_sh = {1'b0, s_r.tx_sh[8:1]};
            s_nxt.tx_bitn = s_r.tx_bitn + 4'h1;
          end
        end
        TX_PAR: begin
          s_nxt.txd = 1'b1;
          s_nxt.tx_st = TX_STOP;
        end
        TX_STOP: begin
          if (s_r.cfg.two_stop && s_r.tx_bitn == 4'h0) begin
            s_nxt.tx_bitn = 4'h1;
          end else if (s_r.tx_buf_valid) begin
            s_nxt.tx_st = TX_START;
          end else begin
            s_nxt.tx_st = TX_IDLE;
          end
        end
        default: begin
          s_nxt.tx_st = TX_IDLE;
        end
      endcase
      // Load of the shift register, start bit goes out at once
      if (s_nxt.tx_st == TX_START) begin
        s_nxt.txd = 1'b0;
        s_nxt.tx_sh = s_r.tx_buf & mask;
        s_nxt.tx_par = (^(s_r.tx_buf & mask)) ^ s_r.cfg.parity_mode[0];
        s_nxt.tx_buf_valid = 1'b0;
      end
    end

    // Done clears first so a frame ending now still sets it
    if (tx_done_serviced_i || (wr && ofs == `OFS_CTRL_STATUS_A && dat_i[`CSA_TX_DONE])) begin
      s_nxt.tx_done = 1'b0;
    end
    if (tx_step && s_r.tx_st == TX_STOP && s_nxt.tx_st == TX_IDLE) begin
      s_nxt.tx_done = 1'b1;
    end

    // ----------------------------------------
    // Register writes
    // ----------------------------------------
    if (wr) begin
      if (ofs == `OFS_DATA_PORT) begin
        // Ninth bit is whatever software staged beforehand
        s_nxt.tx_buf = {s_r.tx_ninth_bit, dat_i[7:0]};
        s_nxt.tx_buf_valid = 1'b1;
      end else if (ofs == `OFS_CTRL_STATUS_B) begin
        s_nxt.tx_done_ie = dat_i[`CSB_TX_DONE_IE];
        s_nxt.tx_empty_ie = dat_i[`CSB_TX_EMPTY_IE];
        s_nxt.rx_on = dat_i[`CSB_RX_ON];
        s_nxt.tx_on = dat_i[`CSB_TX_ON];
        s_nxt.tx_ninth_bit = dat_i[`CSB_TX_NINTH];
      end else if (ofs == `OFS_FRAME_CFG) begin
        s_nxt.cfg.char_size_sel = dat_i[`CFG_SIZE_MSB:`CFG_SIZE_LSB];
        s_nxt.cfg.parity_mode = dat_i[`CFG_PAR_MSB:`CFG_PAR_LSB];
        s_nxt.cfg.two_stop = dat_i[`CFG_TWO_STOP];
        s_nxt.cfg.sync_mode = dat_i[`CFG_SYNC];
      end else if (ofs == `OFS_BAUD_DIV) begin
        s_nxt.baud_div = dat_i[11:0];
      end
    end

    // ----------------------------------------
    // Receiver
    // ----------------------------------------
    if (os_tick) begin
      s_nxt.rx_sub = s_r.rx_sub + 4'h1;
    end
    ent.frame_err = ~rxd;
    ent.overrun = 1'b0;
    ent.parity_err = s_r.cfg.parity_mode[1] &
                     (s_r.rx_parbit ^ (^rdata) ^ s_r.cfg.parity_mode[0]);
    ent.ninth = rdata[8];
    ent.data = rdata[7:0];
    unique case (s_r.rx_st)
      RX_IDLE: begin
        if ((s_r.cfg.sync_mode ? xck_rise : os_tick) && !rxd) begin
          s_nxt.rx_st = s_r.cfg.sync_mode ? RX_DATA : RX_START;
          s_nxt.rx_sub = 4'h0;
          s_nxt.rx_bitn = 4'h0;
        end
      end
      RX_START: begin
        if (os_tick && s_r.rx_sub == `OS_MID) begin
          // Glitch shorter than half a bit is not a start bit
          s_nxt.rx_st = rxd ? RX_IDLE : RX_DATA;
          s_nxt.rx_sub = 4'h0;
        end
      end
      RX_DATA: begin
        if (rx_samp) begin
          s_nxt.rx_sh = {rxd, s_r.rx_sh[8:1]};
          s_nxt.rx_bitn = s_r.rx_bitn + 4'h1;
          if (s_r.rx_bitn + 4'h1 == nbits) begin
            s_nxt.rx_st = s_r.cfg.parity_mode[1] ? RX_PAR : RX_STOP;
          end
        end
      end
      RX_PAR: begin
        if (rx_samp) begin
          s_nxt.rx_parbit = rxd;
          s_nxt.rx_st = RX_STOP;
        end
      end
      RX_STOP: begin
        if (rx_samp) begin
          // Only the first stop bit is looked at
          s_nxt.rx_st = RX_IDLE;
          if (s_r.count == 2'h2 && !s_r.hold_valid) begin
            s_nxt.hold = ent;
            s_nxt.hold_valid = 1'b1;
          end else if (!s_r.hold_valid) begin
            push = 1'b1;
          end
        end
      end
      default: begin
        s_nxt.rx_st = RX_IDLE;
      end
    endcase
    // Confirmed start while full loses the frame
    if (s_r.hold_valid && s_nxt.rx_st == RX_DATA && s_r.rx_st != RX_DATA) begin
      s_nxt.hold.overrun = 1'b1;
    end
    // Parked character moves in as soon as a slot frees
    if (!push && s_r.hold_valid && s_r.count != 2'h2) begin
      ent = s_r.hold;
      push = 1'b1;
      s_nxt.hold_valid = 1'b0;
    end
    if (push) begin
      s_nxt.fifo[s_r.rd_ptr ^ s_r.count[0]] = ent;
    end
    if (pop) begin
      s_nxt.rd_ptr = ~s_r.rd_ptr;
    end
    s_nxt.count = s_r.count + {1'b0, push} - {1'b0, pop};
    if (!s_r.rx_on) begin
      s_nxt.count = 2'h0;
      s_nxt.hold_valid = 1'b0;
      s_nxt.rx_st = RX_IDLE;
    end

    // ----------------------------------------
    // Interrupt requests
    // ----------------------------------------
    s_nxt.tx_empty_irq = global_irq_en_i & s_nxt.tx_empty_ie & ~s_nxt.tx_buf_valid;
    s_nxt.tx_done_irq = global_irq_en_i & s_nxt.tx_done_ie & s_nxt.tx_done;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r <= '0;
      s_r.cfg <= frame_cfg_t'(`CFG_RST);
      s_r.baud_div <= `BAUD_DIV_RST;
      s_r.txd <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign dat_o = s_r.rdat;
  assign ack_o = s_r.ack;
  assign serial_out_o = s_r.txd;
  assign tx_override_o = s_r.tx_en_eff;
  assign rx_override_o = s_r.rx_on;
  assign tx_empty_irq_o = s_r.tx_empty_irq;
  assign tx_done_irq_o = s_r.tx_done_irq;

endmodule

// *** test/usart_datapath_props.sv ***
// Port-level checks for the serial data path
`timescale 1ns/1ps
module usart_datapath_props (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  // Serial pins and interrupts
  input wire logic serial_out_o,
  input wire logic tx_override_o,
  input wire logic rx_override_o,
  input wire logic global_irq_en_i,
  input wire logic tx_done_serviced_i,
  input wire logic tx_empty_irq_o,
  input wire logic tx_done_irq_o
);
  // ------------------------------
  // Helpers
  // ------------------------------
  logic csb_wr;
  assign csb_wr = cyc_i && stb_i && !ack_o && we_i && adr_i[7:2] == 6'h02 && sel_i[0];
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ------------------------------
  // Assertions
  // ------------------------------
  ack_pulse_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
    else $error("ack not a single pulse");
  dat_quiet_a: assert property (!ack_o |-> dat_o == 32'h0)
    else $error("read data outside ack");
  empty_gate_a: assert property (tx_empty_irq_o |-> $past(global_irq_en_i))
    else $error("empty irq without global enable");
  done_gate_a: assert property (tx_done_irq_o |-> $past(global_irq_en_i))
    else $error("done irq without global enable");
  done_clear_a: assert property (tx_done_serviced_i && tx_done_irq_o |=> ##1 !tx_done_irq_o)
    else $error("done irq survives service");
  pin_release_a: assert property (!tx_override_o |-> serial_out_o)
    else $error("line driven low while released");
  start_len_a: assert property ($fell(serial_out_o) |-> !serial_out_o [*8])
    else $error("start bit too short");
  rx_take_a: assert property (csb_wr && dat_i[4] |-> ##[1:2] rx_override_o)
    else $error("receiver did not take input pin");
  rx_drop_a: assert property (csb_wr && !dat_i[4] |-> ##[1:2] !rx_override_o)
    else $error("receiver kept input pin");
  tx_take_a: assert property (csb_wr && dat_i[3] |-> ##[1:2] tx_override_o)
    else $error("transmitter did not take output pin");
endmodule

bind usart_datapath usart_datapath_props usart_datapath_props_inst (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
  .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .serial_out_o(serial_out_o),
  .tx_override_o(tx_override_o), .rx_override_o(rx_override_o),
  .global_irq_en_i(global_irq_en_i), .tx_done_serviced_i(tx_done_serviced_i),
  .tx_empty_irq_o(tx_empty_irq_o), .tx_done_irq_o(tx_done_irq_o));

// *** test/serial_node_model.sv ***
// Remote serial node: frame sender and mid-bit frame decoder
`timescale 1ns/1ps
module serial_node_model (
  // Clock
  input wire logic clk_i,
  // Serial lines
  input wire logic line_i,
  output logic line_o,
  output logic xck_o
);
  int nbits = 8;
  int i;
  logic par_en = 1'b0;
  logic par_odd = 1'b0;
  logic sync = 1'b0;
  logic [11:0] v;
  logic [11:0] got_q[$];

  initial begin
    line_o = 1'b1;  // Idle mark level
    xck_o = 1'b0;
  end

  // ------------------------------
  // Decoder, bit = 16 clocks
  // ------------------------------
  always begin
    @(negedge line_i);
    repeat (8) @(posedge clk_i);
    if (line_i === 1'b0) begin
      v = 12'h0;
      for (i = 0; i < nbits + 1 + int'(par_en); i++) begin
        repeat (16) @(posedge clk_i);
        v[i] = line_i;
      end
      got_q.push_back(v);
    end
  end

  task automatic setup(input int n, input logic pe, input logic po, input logic s);
    nbits = n;
    par_en = pe;
    par_odd = po;
    sync = s;
  endtask

  // Transfer clock rises mid-bit only inside frames, stands still between them
  task automatic put(input logic b);
    xck_o <= 1'b0;
    line_o <= b;
    repeat (8) @(posedge clk_i);
    if (sync) xck_o <= 1'b1;
    repeat (8) @(posedge clk_i);
  endtask

  task automatic send(input logic [8:0] d, input logic bad_par, input logic stop);
    int k;
    @(posedge clk_i);
    put(1'b0);
    for (k = 0; k < nbits; k++) put(d[k]);  // LSB first
    if (par_en) put((^(d & ~(9'h1ff << nbits))) ^ par_odd ^ bad_par);
    put(stop);  // One stop only, second one optional
    line_o <= 1'b1;
  endtask

  // Short low pulse, too short for a start bit
  task automatic glitch();
    @(posedge clk_i);
    line_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    line_o <= 1'b1;
  endtask
endmodule

// *** test/usart_datapath_bench.sv ***
// Self-checking bench for the serial data path
`timescale 1ns/1ps
`include "usart_defines.svh"
module usart_datapath_bench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic global_irq_en_i = 1'b0;
  logic tx_done_serviced_i = 1'b0;
  logic [31:0] dat_o;
  logic [31:0] q;
  logic ack_o, serial_in_i, ext_serial_clk_i, serial_out_o, tx_override_o, rx_override_o;
  logic tx_empty_irq_o, tx_done_irq_o;
  int error_cnt = 0;
  int checks = 0;

  always #4 clk_i = ~clk_i;

  usart_datapath usart_datapath_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .serial_in_i(serial_in_i), .ext_serial_clk_i(ext_serial_clk_i),
    .serial_out_o(serial_out_o), .tx_override_o(tx_override_o), .rx_override_o(rx_override_o),
    .global_irq_en_i(global_irq_en_i), .tx_done_serviced_i(tx_done_serviced_i),
    .tx_empty_irq_o(tx_empty_irq_o), .tx_done_irq_o(tx_done_irq_o));
  serial_node_model serial_node_model_inst (.clk_i(clk_i), .line_i(serial_out_o),
    .line_o(serial_in_i), .xck_o(ext_serial_clk_i));

  // ------------------------------
  // Shared tasks
  // ------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Classic cycle; request held until ack is seen, released at that edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hf;
    do begin
      @(posedge clk_i);
      n++;
      if (n > 20) begin
        error_cnt++;
        report_and_stop();
      end
    end while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    wb(1'b0, a, 32'h0);
    check(what, q, exp);
  endtask

  task automatic expect_tx(input logic [8:0] d, input int nb, input logic pe, input logic po);
    logic [11:0] e;
    int k;
    k = 0;
    while (serial_node_model_inst.got_q.size() == 0) begin
      @(posedge clk_i);
      k++;
      if (k > 4000) begin
        error_cnt++;
        report_and_stop();
      end
    end
    e = 12'(d & ~(9'h1ff << nb));
    if (pe) e[nb] = ^e ^ po;
    e[nb + int'(pe)] = 1'b1;
    check("tx frame", {20'h0, serial_node_model_inst.got_q.pop_front()}, {20'h0, e});
    repeat (16) @(posedge clk_i);
  endtask

  // ------------------------------
  // Scenarios
  // ------------------------------
  task automatic t_tx();
    rd(`OFS_CTRL_STATUS_A, 32'h20, "reset status a");
    rd(`OFS_FRAME_CFG, 32'h03, "reset cfg");
    rd(`OFS_BAUD_DIV, 32'h43, "reset baud");
    rd(8'h14, 32'h0, "unmapped");
    wb(1'b1, `OFS_BAUD_DIV, 32'h0);
    global_irq_en_i <= 1'b1;
    wb(1'b1, `OFS_CTRL_STATUS_B, 32'h28);
    check("empty irq", {31'h0, tx_empty_irq_o}, 32'h1);
    wb(1'b1, `OFS_DATA_PORT, 32'ha5);
    repeat (16) @(posedge clk_i);
    wb(1'b1, `OFS_DATA_PORT, 32'h3c);
    rd(`OFS_CTRL_STATUS_A, 32'h00, "buffer held");
    check("empty irq held", {31'h0, tx_empty_irq_o}, 32'h0);
    expect_tx(9'h0a5, 8, 1'b0, 1'b0);
    expect_tx(9'h03c, 8, 1'b0, 1'b0);
    rd(`OFS_CTRL_STATUS_A, 32'h60, "tx done");
    wb(1'b1, `OFS_CTRL_STATUS_A, 32'h40);  // Zero at the empty position
    rd(`OFS_CTRL_STATUS_A, 32'h20, "done cleared");
    $display("test tx done");
  endtask

  task automatic t_done_irq();
    wb(1'b1, `OFS_CTRL_STATUS_B, 32'h48);
    wb(1'b1, `OFS_DATA_PORT, 32'h81);
    expect_tx(9'h081, 8, 1'b0, 1'b0);
    check("done irq", {31'h0, tx_done_irq_o}, 32'h1);
    tx_done_serviced_i <= 1'b1;
    @(posedge clk_i);
    tx_done_serviced_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    check("done irq cleared", {31'h0, tx_done_irq_o}, 32'h0);
    rd(`OFS_CTRL_STATUS_A, 32'h20, "serviced flag");
    $display("test done irq done");
  endtask

  task automatic t_parity();
    wb(1'b1, `OFS_FRAME_CFG, 32'h27);
    serial_node_model_inst.setup(9, 1'b1, 1'b0, 1'b0);
    wb(1'b1, `OFS_CTRL_STATUS_B, 32'h09);  // Ninth bit before low byte
    wb(1'b1, `OFS_DATA_PORT, 32'h55);
    expect_tx(9'h155, 9, 1'b1, 1'b0);
    wb(1'b1, `OFS_FRAME_CFG, 32'h37);
    wb(1'b1, `OFS_CTRL_STATUS_B, 32'h08);
    wb(1'b1, `OFS_DATA_PORT, 32'h1f0);
    expect_tx(9'h0f0, 9, 1'b1, 1'b1);
    $display("test parity done");
  endtask

  task automatic t_disable();
    wb(1'b1, `OFS_FRAME_CFG, 32'h03);
    serial_node_model_inst.setup(8, 1'b0, 1'b0, 1'b0);
    wb(1'b1, `OFS_DATA_PORT, 32'hc3);
    wb(1'b1, `OFS_CTRL_STATUS_B, 32'h00);
    check("still owned", {31'h0, tx_override_o}, 32'h1);
    expect_tx(9'h0c3, 8, 1'b0, 1'b0);
    check("released", {31'h0, tx_override_o}, 32'h0);
    wb(1'b1, `OFS_CTRL_STATUS_A, 32'h40);
    $display("test disable done");
  endtask

  task automatic t_rx();
    wb(1'b1, `OFS_FRAME_CFG, 32'h00);
    wb(1'b1, `OFS_CTRL_STATUS_B, 32'h10);
    check("rx owns pin", {31'h0, rx_override_o}, 32'h1);
    serial_node_model_inst.setup(5, 1'b0, 1'b0, 1'b0);
    serial_node_model_inst.send(9'h015, 1'b0, 1'b1);
    serial_node_model_inst.send(9'h00a, 1'b0, 1'b1);
    serial_node_model_inst.send(9'h01f, 1'b0, 1'b1);
    rd(`OFS_CTRL_STATUS_A, 32'ha0, "rx ready");
    rd(`OFS_DATA_PORT, 32'h15, "rx first");
    rd(`OFS_DATA_PORT, 32'h0a, "rx second");
    rd(`OFS_DATA_PORT, 32'h1f, "rx third");
    rd(`OFS_CTRL_STATUS_A, 32'h20, "rx drained");
    serial_node_model_inst.glitch();
    repeat (200) @(posedge clk_i);
    rd(`OFS_CTRL_STATUS_A, 32'h20, "glitch ignored");
    $display("test rx done");
  endtask

  task automatic t_rx_err();
    wb(1'b1, `OFS_FRAME_CFG, 32'h67);
    serial_node_model_inst.setup(9, 1'b1, 1'b0, 1'b0);
    serial_node_model_inst.send(9'h1aa, 1'b1, 1'b1);
    serial_node_model_inst.send(9'h055, 1'b0, 1'b1);
    serial_node_model_inst.send(9'h100, 1'b0, 1'b0);
    rd(`OFS_CTRL_STATUS_A, 32'ha4, "parity err");
    rd(`OFS_CTRL_STATUS_B, 32'h12, "ninth a");
    rd(`OFS_DATA_PORT, 32'haa, "data a");
    rd(`OFS_CTRL_STATUS_A, 32'ha0, "one stop ok");
    rd(`OFS_CTRL_STATUS_B, 32'h10, "ninth b");
    rd(`OFS_DATA_PORT, 32'h55, "data b");
    rd(`OFS_CTRL_STATUS_A, 32'hb0, "frame err");
    rd(`OFS_CTRL_STATUS_B, 32'h12, "ninth c");
    rd(`OFS_DATA_PORT, 32'h00, "data c");
    $display("test rx errors done");
  endtask

  task automatic t_sync();
    wb(1'b1, `OFS_FRAME_CFG, 32'h83);
    serial_node_model_inst.setup(8, 1'b0, 1'b0, 1'b1);
    serial_node_model_inst.send(9'h0e7, 1'b0, 1'b1);
    rd(`OFS_DATA_PORT, 32'he7, "sync rx");
    wb(1'b1, `OFS_CTRL_STATUS_B, 32'h00);
    check("rx released", {31'h0, rx_override_o}, 32'h0);
    $display("test sync done");
  endtask

  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_tx();
    t_done_irq();
    t_parity();
    t_disable();
    t_rx();
    t_rx_err();
    t_sync();
    report_and_stop();
  end
endmodule
